// [rtl/host_port_pkg.sv]
// constants for the host multiplexed bus port
package host_port_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int REG_SEL_W = 3;
	localparam int NUM_REGS = 8;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [1:0] GRANT_HOST = 2'h0;
	localparam logic [1:0] GRANT_NONE = 2'h3;
	localparam logic [1:0] GRANT_REQ1 = 2'h1;
	localparam logic [1:0] GRANT_REQ2 = 2'h2;
	localparam logic [1:0] GRANT_REQ3 = 2'h3;
	localparam logic WRITE_LEVEL = 1'b0;
endpackage

// [rtl/host_reg_mem.sv]
// small register bank with registered read data
module host_reg_mem #(
	parameter int DATA_W = 8,
	parameter int SEL_W = 3
) (
	input wire logic i_clk, // clock
	input wire logic i_rst, // sync reset
	input wire logic i_we, // write strobe
	input wire logic [SEL_W-1:0] i_sel, // register index
	input wire logic [DATA_W-1:0] i_wdata, // write data
	output logic [DATA_W-1:0] o_rdata // registered read data
);
	logic [DATA_W-1:0] mem [2**SEL_W];
	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		next_rdata = mem[i_sel];
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= host_port_pkg::DATA_RESET;
		end else begin
			o_rdata <= next_rdata;
		end
	end

	genvar g;
	for (g = 0; g < 2**SEL_W; g++) begin : g_reg
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				mem[g] <= host_port_pkg::DATA_RESET;
			end else if (i_we && i_sel == SEL_W'(g)) begin
				mem[g] <= i_wdata;
			end
		end
	end
endmodule // host_reg_mem

// [rtl/host_muxed_bus_port.sv]
// host multiplexed address/data port with register access and grant
module host_muxed_bus_port #(
	parameter int ADDR_W = host_port_pkg::ADDR_W,
	parameter int DATA_W = host_port_pkg::DATA_W,
	parameter int REG_SEL_W = host_port_pkg::REG_SEL_W
) (
	input wire logic i_clk, // ram clock
	input wire logic i_rst, // sync reset, active high
	input wire logic [ADDR_W-1:0] i_shared_addr_data_bus, // shared lines in
	output logic [ADDR_W-1:0] o_shared_addr_data_bus, // shared lines out
	output logic o_shared_addr_data_bus_oe, // drive enable of data byte
	input wire logic i_addr_strobe, // address strobe, high passes
	input wire logic i_register_select_n, // register select, low active
	input wire logic i_write_direction, // low write, high read
	input wire logic i_host_access_request, // host memory request
	input wire logic [2:0] i_dma_request, // dma requests 1..3
	output logic [ADDR_W-1:0] o_ram_addr, // latched address to ram
	output logic o_grant_enable_n, // grant valid, low active
	output logic o_grant_code_bit0, // grant code bit 0
	output logic o_grant_code_bit1 // grant code bit 1
);
	if (ADDR_W != host_port_pkg::ADDR_W || DATA_W != host_port_pkg::DATA_W
		|| REG_SEL_W < 1 || REG_SEL_W > ADDR_W) begin : g_bad_width
		$error("host_muxed_bus_port: unsupported widths");
	end

	// ----------------------------------------
	// address latch
	// ----------------------------------------
	logic [ADDR_W-1:0] addr_latch;
	logic [ADDR_W-1:0] next_addr_latch;

	always_comb begin
		next_addr_latch = addr_latch;
		if (i_addr_strobe) begin
			next_addr_latch = i_shared_addr_data_bus;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			addr_latch <= host_port_pkg::ADDR_RESET;
			o_ram_addr <= host_port_pkg::ADDR_RESET;
		end else begin
			addr_latch <= next_addr_latch;
			o_ram_addr <= next_addr_latch;
		end
	end

	// ----------------------------------------
	// register access
	// ----------------------------------------
	logic sel_d;
	logic next_sel_d;
	logic reg_we;
	logic [DATA_W-1:0] reg_rdata;
	logic next_oe;
	logic [ADDR_W-1:0] next_bus_out;

	// one write per select assertion, data after strobe is low
	assign reg_we = !i_register_select_n && !sel_d && !i_addr_strobe
		&& i_write_direction == host_port_pkg::WRITE_LEVEL;

	host_reg_mem #(
		.DATA_W(DATA_W),
		.SEL_W(REG_SEL_W)
	) u_regs (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_we(reg_we),
		.i_sel(addr_latch[REG_SEL_W-1:0]),
		.i_wdata(i_shared_addr_data_bus[DATA_W-1:0]),
		.o_rdata(reg_rdata)
	);

	always_comb begin
		next_sel_d = !i_register_select_n;
		next_oe = !i_register_select_n && i_write_direction != host_port_pkg::WRITE_LEVEL
			&& !i_addr_strobe;
		next_bus_out = {{(ADDR_W-DATA_W){1'b0}}, reg_rdata};
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sel_d <= 1'b0;
			o_shared_addr_data_bus_oe <= 1'b0;
			o_shared_addr_data_bus <= host_port_pkg::ADDR_RESET;
		end else begin
			sel_d <= next_sel_d;
			o_shared_addr_data_bus_oe <= next_oe;
			o_shared_addr_data_bus <= next_bus_out;
		end
	end

	// ----------------------------------------
	// grant of next memory cycle
	// ----------------------------------------
	logic [1:0] next_code;
	logic next_gen_n;

	// fixed priority, req3 highest, host lowest
	always_comb begin
		next_gen_n = 1'b0;
		next_code = host_port_pkg::GRANT_NONE;
		if (i_dma_request[2]) begin
			next_code = host_port_pkg::GRANT_REQ3;
		end else if (i_dma_request[1]) begin
			next_code = host_port_pkg::GRANT_REQ2;
		end else if (i_dma_request[0]) begin
			next_code = host_port_pkg::GRANT_REQ1;
		end else if (i_host_access_request) begin
			next_code = host_port_pkg::GRANT_HOST;
		end else begin
			next_gen_n = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_grant_enable_n <= 1'b1;
			o_grant_code_bit0 <= 1'b1;
			o_grant_code_bit1 <= 1'b1;
		end else begin
			o_grant_enable_n <= next_gen_n;
			o_grant_code_bit0 <= next_code[0];
			o_grant_code_bit1 <= next_code[1];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_latch_follow;
		@(posedge i_clk) disable iff (i_rst)
		i_addr_strobe |=> o_ram_addr == $past(i_shared_addr_data_bus);
	endproperty
	a_latch_follow: assert property (p_latch_follow) else $error("latch missed bus");

	property p_latch_hold;
		@(posedge i_clk) disable iff (i_rst)
		!i_addr_strobe ##1 !i_addr_strobe |-> $stable(o_ram_addr);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch moved");

	property p_read_drive;
		@(posedge i_clk) disable iff (i_rst)
		(!i_register_select_n && i_write_direction && !i_addr_strobe)
			|=> o_shared_addr_data_bus_oe;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not driven");

	property p_release;
		@(posedge i_clk) disable iff (i_rst)
		i_register_select_n |=> !o_shared_addr_data_bus_oe;
	endproperty
	a_release: assert property (p_release) else $error("drive after select");

	property p_no_drive_write;
		@(posedge i_clk) disable iff (i_rst)
		!i_write_direction |=> !o_shared_addr_data_bus_oe;
	endproperty
	a_no_drive_write: assert property (p_no_drive_write) else $error("drive in write");

	property p_host_grant;
		@(posedge i_clk) disable iff (i_rst)
		(i_host_access_request && i_dma_request == 3'h0)
			|=> !o_grant_enable_n && !o_grant_code_bit0 && !o_grant_code_bit1;
	endproperty
	a_host_grant: assert property (p_host_grant) else $error("host not granted");

	property p_idle;
		@(posedge i_clk) disable iff (i_rst)
		(!i_host_access_request && i_dma_request == 3'h0) |=> o_grant_enable_n;
	endproperty
	a_idle: assert property (p_idle) else $error("grant without request");

	property p_dma_wins;
		@(posedge i_clk) disable iff (i_rst)
		(i_dma_request != 3'h0) |=> !o_grant_enable_n
			&& {o_grant_code_bit1, o_grant_code_bit0} != host_port_pkg::GRANT_HOST;
	endproperty
	a_dma_wins: assert property (p_dma_wins) else $error("dma lost");

	property p_req3_wins;
		@(posedge i_clk) disable iff (i_rst)
		i_dma_request[2] |=> !o_grant_enable_n
			&& {o_grant_code_bit1, o_grant_code_bit0} == host_port_pkg::GRANT_REQ3;
	endproperty
	a_req3_wins: assert property (p_req3_wins) else $error("req3 not granted");

	property p_req2_wins;
		@(posedge i_clk) disable iff (i_rst)
		(i_dma_request[2:1] == 2'h1) |=> !o_grant_enable_n
			&& {o_grant_code_bit1, o_grant_code_bit0} == host_port_pkg::GRANT_REQ2;
	endproperty
	a_req2_wins: assert property (p_req2_wins) else $error("req2 not granted");

	property p_req1_wins;
		@(posedge i_clk) disable iff (i_rst)
		(i_dma_request == 3'h1) |=> !o_grant_enable_n
			&& {o_grant_code_bit1, o_grant_code_bit0} == host_port_pkg::GRANT_REQ1;
	endproperty
	a_req1_wins: assert property (p_req1_wins) else $error("req1 not granted");

	property p_strobe_no_drive;
		@(posedge i_clk) disable iff (i_rst)
		i_addr_strobe |=> !o_shared_addr_data_bus_oe;
	endproperty
	a_strobe_no_drive: assert property (p_strobe_no_drive) else $error("drive in address");

	property p_drive_needs_select;
		@(posedge i_clk) disable iff (i_rst)
		o_shared_addr_data_bus_oe |-> $past(!i_register_select_n);
	endproperty
	a_drive_needs_select: assert property (p_drive_needs_select) else $error("drive no select");

	property p_read_upper_zero;
		@(posedge i_clk) disable iff (i_rst)
		o_shared_addr_data_bus_oe |-> o_shared_addr_data_bus[ADDR_W-1:DATA_W] == '0;
	endproperty
	a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper lines driven");
endmodule // host_muxed_bus_port

// [verification/host_cpu_model.sv]
// host processor model driving the multiplexed bus cycles
module host_cpu_model (
	input wire logic i_clk, // ram clock
	input wire logic i_oe, // device drives data byte
	input wire logic [15:0] i_dev, // device data lines
	output logic [15:0] o_bus, // wire level seen by the device
	output logic o_strobe, // address strobe
	output logic o_sel_n, // register select, low active
	output logic o_dir // low write, high read
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] drv = 16'h0000;
	initial begin
		o_strobe = 1'b0;
		o_sel_n = 1'b1;
		o_dir = 1'b1;
	end
	assign o_bus = i_oe ? {drv[15:8], i_dev[7:0]} : drv;
	// ----------------------------------------
	// one access: address phase, then select held n edges
	// ----------------------------------------
	task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d,
		input int n, output logic [7:0] rd, output logic rdo);
		@(posedge i_clk);
		#1 drv = a;
		o_strobe = 1'b1;
		@(posedge i_clk);
		#1 o_strobe = 1'b0;
		drv = ~a;
		@(posedge i_clk);
		#1 o_dir = w;
		o_sel_n = 1'b0;
		if (!w) drv[7:0] = d;
		repeat (n) @(posedge i_clk);
		#1 rd = i_dev[7:0];
		rdo = i_oe;
		o_sel_n = 1'b1;
		o_dir = 1'b1;
		drv = ~drv;
	endtask
endmodule // host_cpu_model

// [verification/tb.sv]
// self-checking bench for the host multiplexed bus port
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, req = 1'b0, oe, gen, g0, g1, stb, sel_n, dir, rdo;
	logic [2:0] dma = 3'h0;
	logic [15:0] bus, dev, ram;
	logic [7:0] rd;
	int mismatches = 0, checks = 0, cycles = 0;
	initial forever #5 clk = ~clk;
	host_muxed_bus_port u_host_muxed_bus_port (.i_clk(clk), .i_rst(rst),
		.i_shared_addr_data_bus(bus), .o_shared_addr_data_bus(dev),
		.o_shared_addr_data_bus_oe(oe), .i_addr_strobe(stb), .i_register_select_n(sel_n),
		.i_write_direction(dir), .i_host_access_request(req), .i_dma_request(dma),
		.o_ram_addr(ram), .o_grant_enable_n(gen), .o_grant_code_bit0(g0),
		.o_grant_code_bit1(g1));
	host_cpu_model u_host_cpu_model (.i_clk(clk), .i_oe(oe), .i_dev(dev), .o_bus(bus),
		.o_strobe(stb), .o_sel_n(sel_n), .o_dir(dir));
	// ----------------------------------------
	// checks and scenarios
	// ----------------------------------------
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checks++;
		if (e !== s) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			mismatches++;
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic test_write();
		u_host_cpu_model.cyc(16'h1235, 1'b0, 8'hA5, 2, rd, rdo);
		chk("ram addr", 16'h1235, ram);
		chk("oe on write", 16'h0000, {15'h0000, rdo});
		u_host_cpu_model.cyc(16'hBEE2, 1'b0, 8'h3C, 2, rd, rdo);
		chk("ram addr", 16'hBEE2, ram);
		$display("test_write done");
	endtask
	task automatic test_read();
		u_host_cpu_model.cyc(16'h1235, 1'b1, 8'h00, 5, rd, rdo);
		chk("read reg5", 16'h00A5, {8'h00, rd});
		chk("oe held", 16'h0001, {15'h0000, rdo});
		u_host_cpu_model.cyc(16'h00F2, 1'b1, 8'h00, 3, rd, rdo);
		chk("read reg2", 16'h003C, {8'h00, rd});
		@(posedge clk);
		#1 chk("oe released", 16'h0000, {15'h0000, oe});
		$display("test_read done");
	endtask
	task automatic test_grant();
		logic [3:0] stim [5] = '{4'h1, 4'h3, 4'h5, 4'h9, 4'h0};
		logic [2:0] ex [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
		for (int i = 0; i < 5; i++) begin
			{dma, req} = stim[i];
			@(posedge clk);
			#1 chk("grant", {13'h0000, ex[i]}, {13'h0000, gen, g1, g0});
		end
		$display("test_grant done");
	endtask
	task automatic test_reset();
		req = 1'b1;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("ram addr in reset", 16'h0000, ram);
		chk("bus out in reset", 16'h0000, dev);
		chk("grant in reset", 16'h0007, {13'h0000, gen, g1, g0});
		rst = 1'b0;
		@(posedge clk);
		#1 chk("grant after reset", 16'h0000, {13'h0000, gen, g1, g0});
		req = 1'b0;
		u_host_cpu_model.cyc(16'h0005, 1'b1, 8'h00, 2, rd, rdo);
		chk("reg5 cleared", 16'h0000, {8'h00, rd});
		chk("read bus upper", 16'h0000, {dev[15:8], 8'h00});
		chk("oe after reset", 16'h0001, {15'h0000, rdo});
		$display("test_reset done");
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		test_write();
		test_read();
		test_grant();
		test_reset();
		results();
	end
endmodule // tb
